//--- logic/caption_erase_defines.svh
// Timing and reset constants for the caption erase and autoblank block.
`ifndef CAPTION_ERASE_DEFINES_SVH
`define CAPTION_ERASE_DEFINES_SVH

// =====================================================================
// Time base
// Video fields per second; all intervals are counted in fields.
`define FIELDS_PER_SEC  60
`define MS_PER_SEC      1000

// =====================================================================
// Intervals, as printed, in milliseconds
`define ACQ_TIME_MS     500
`define LOSS_TIME_MS    1500
`define ERASE_TIME_MS   16000

// Field counts derived from the times, rounded up to whole fields.
`define ACQ_FIELDS   ((`ACQ_TIME_MS * `FIELDS_PER_SEC + `MS_PER_SEC - 1) \
	/ `MS_PER_SEC)
`define LOSS_FIELDS  ((`LOSS_TIME_MS * `FIELDS_PER_SEC + `MS_PER_SEC - 1) \
	/ `MS_PER_SEC)
`define ERASE_FIELDS ((`ERASE_TIME_MS * `FIELDS_PER_SEC + `MS_PER_SEC - 1) \
	/ `MS_PER_SEC)

// =====================================================================
// Waveform recognition
`define RUNIN_CYCLES    7

// =====================================================================
// Reset values
`define DECODER_ON_RESET   1'h0
`define ERASE_TIMER_RESET  1'h1

`endif

//--- logic/caption_erase_pkg.sv
// Types and mode helpers for the caption erase and autoblank block.
package caption_erase_pkg;

	// =================================================================
	// Display modes
	typedef enum logic [3:0] {
		first_caption_channel,
		second_caption_channel,
		third_caption_channel,
		fourth_caption_channel,
		text_one,
		text_two,
		text_three,
		text_four,
		full_info_template,
		grazing_template,
		user_osd
	} display_mode_e;

	// Autoblank supervisor states.
	typedef enum logic {
		ACQUIRE,
		SHOWING
	} blank_state_e;

	// True for the four caption channels.
	function automatic logic mode_is_caption(display_mode_e m);
		return (m == first_caption_channel) ||
			(m == second_caption_channel) ||
			(m == third_caption_channel) ||
			(m == fourth_caption_channel);
	endfunction

	// True for the four text channels.
	function automatic logic mode_is_text(display_mode_e m);
		return (m == text_one) || (m == text_two) ||
			(m == text_three) || (m == text_four);
	endfunction

	// True where the long no-data erase timer may run.
	function automatic logic mode_has_timer(display_mode_e m);
		return mode_is_caption(m) || (m == full_info_template) ||
			(m == grazing_template);
	endfunction

	// True where the mode's data rides in the second (even) field.
	function automatic logic mode_in_field2(display_mode_e m);
		return (m == third_caption_channel) ||
			(m == fourth_caption_channel) || (m == text_three) ||
			(m == text_four) || (m == full_info_template) ||
			(m == grazing_template) || (m == user_osd);
	endfunction

endpackage

//--- logic/field_interval.sv
// Field-tick interval counter with a one-cycle done pulse.
`timescale 1ns/100ps
module field_interval
	import caption_erase_pkg::*;
#(
	parameter int LIMIT = 30,
	parameter int W     = $clog2(LIMIT + 1)
) (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Control.
	input  wire logic tick,
	input  wire logic run,
	input  wire logic restart,
	// Result.
	output logic      done_reg
);

	// =================================================================
	// Parameter check
	if (LIMIT < 1) begin : g_bad_limit
		$error("field_interval: LIMIT must be at least one");
	end

	logic [W-1:0] cnt_reg;

	// Count ticks while running; a restart or a pause starts over.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || restart || !run) begin
			cnt_reg <= '0;
		end else if (tick) begin
			if (cnt_reg == W'(LIMIT - 1)) begin
				cnt_reg <= '0;
			end else begin
				cnt_reg <= cnt_reg + W'(1);
			end
		end
	end

	// Done pulses the cycle after the tick that completes the interval.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_reg <= 1'h0;
		end else begin
			done_reg <= run && !restart && tick &&
				(cnt_reg == W'(LIMIT - 1));
		end
	end

	// =================================================================
	// Checks
	property p_done_after_tick;
		@(posedge sys_clk) disable iff (!rst_n)
		done_reg |-> $past(tick) && $past(run);
	endproperty
	a_done_after_tick: assert property (p_done_after_tick)
		else $error("interval done without a field tick");

endmodule

//--- logic/line21_detect.sv
// Line 21 waveform check: run-in clock count followed by a start bit.
`timescale 1ns/100ps
`include "caption_erase_defines.svh"
module line21_detect
	import caption_erase_pkg::*;
#(
	parameter int RUNIN = `RUNIN_CYCLES
) (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Slicer events.
	input  wire logic line21_gate,
	input  wire logic runin_cycle,
	input  wire logic start_bit,
	// Verdict at the end of line 21.
	output logic      check_done_reg,
	output logic      check_pass_reg
);

	if (RUNIN < 1 || RUNIN > 15) begin : g_bad_runin
		$error("line21_detect: RUNIN out of range");
	end

	logic [3:0] runin_cnt_reg;
	logic       found_reg;
	logic       gate_prev_reg;

	// Count run-in cycles inside the line, saturating at the target.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !line21_gate) begin
			runin_cnt_reg <= 4'h0;
		end else if (runin_cycle && runin_cnt_reg != 4'(RUNIN)) begin
			runin_cnt_reg <= runin_cnt_reg + 4'h1;
		end
	end

	// A start bit after the full run-in marks a valid waveform.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !line21_gate) begin
			found_reg <= 1'h0;
		end else if (start_bit && runin_cnt_reg == 4'(RUNIN)) begin
			found_reg <= 1'h1;
		end
	end

	// Report once when the line 21 gate closes.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_prev_reg  <= 1'h0;
			check_done_reg <= 1'h0;
			check_pass_reg <= 1'h0;
		end else begin
			gate_prev_reg  <= line21_gate;
			check_done_reg <= gate_prev_reg && !line21_gate;
			check_pass_reg <= found_reg;
		end
	end

	property p_runin_needed;
		@(posedge sys_clk) disable iff (!rst_n)
		line21_gate && start_bit && runin_cnt_reg != 4'(RUNIN) &&
			!found_reg |=> !found_reg;
	endproperty
	a_runin_needed: assert property (p_runin_needed)
		else $error("waveform accepted without full run-in");

endmodule

//--- logic/caption_display_erase_autoblank.sv
// Display erase control and Line 21 autoblank supervisor.
`timescale 1ns/100ps
`include "caption_erase_defines.svh"
// How it works
// - Start text clears text, box kept
// - Erase shown command clears on-screen caption
// - Erase hidden command clears off-screen memory only
// - Display mode change clears memory and screen
// - Lock loss clears screen, mode kept
// - Watch only the selected channel's field
// - Hold off until 0.5 s waveform
// - Blank after 1.5 s waveform absence
// - Data during loss timing restarts count
// - Valid waveform: seven run-in cycles, start bit
// - Erase timer only in caption/XDS modes
// - Sixteen seconds without data erases screen
// - Timer erase keeps channel and decoder state
// - Erase timer enabled after reset, can disable
// - Reset: decoder off, first caption channel
module caption_display_erase_autoblank
	import caption_erase_pkg::*;
#(
	parameter int ACQ_FIELDS   = `ACQ_FIELDS,
	parameter int LOSS_FIELDS  = `LOSS_FIELDS,
	parameter int ERASE_FIELDS = `ERASE_FIELDS
) (
	// Clock and reset.
	input  wire logic    sys_clk,
	input  wire logic    rst_n,
	// Video timing and lock.
	input  wire logic    field_tick,
	input  wire logic    field_even,
	input  wire logic    video_locked,
	// Line 21 slicer events.
	input  wire logic    line21_gate,
	input  wire logic    runin_cycle,
	input  wire logic    start_bit,
	input  wire logic    chan_data_valid,
	// Decoded commands.
	input  wire logic    start_text_cmd,
	input  wire logic    erase_shown_memory_cmd,
	input  wire logic    erase_hidden_memory_cmd,
	// User configuration.
	input  wire logic    cfg_load,
	input  display_mode_e mode_sel,
	input  wire logic    decoder_on_sel,
	input  wire logic    erase_timer_off,
	// Display control.
	output display_mode_e mode_reg,
	output logic         decoder_on_reg,
	output logic         timer_en_reg,
	output logic         display_on_reg,
	output logic         box_on_reg,
	output logic         clear_shown_reg,
	output logic         clear_hidden_reg,
	output logic         text_clear_reg
);

	// =================================================================
	// Parameter check
	if (ACQ_FIELDS < 1 || LOSS_FIELDS < 1 || ERASE_FIELDS < 1)
	begin : g_bad_fields
		$error("caption_display_erase_autoblank: field counts < 1");
	end

	// =================================================================
	// Internal signals
	blank_state_e state_reg;
	blank_state_e state_next;
	logic         lock_prev_reg;
	logic         wave_ok_reg;
	logic         lock_lost;
	logic         mode_change;
	logic         check_done;
	logic         check_pass;
	logic         field_hit;
	logic         acq_run;
	logic         acq_restart;
	logic         acq_done;
	logic         loss_run;
	logic         loss_restart;
	logic         loss_done;
	logic         erase_run;
	logic         erase_restart;
	logic         erase_done;
	logic         show_next;

	// =================================================================
	// Configuration
	// Mode register loads on a configuration strobe.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_reg <= first_caption_channel;
		end else if (cfg_load) begin
			mode_reg <= mode_sel;
		end
	end

	// Decoder on/off follows the user's choice only.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			decoder_on_reg <= `DECODER_ON_RESET;
		end else if (cfg_load) begin
			decoder_on_reg <= decoder_on_sel;
		end
	end

	// Erase timer enable: on after reset, software may turn it off.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			timer_en_reg <= `ERASE_TIMER_RESET;
		end else begin
			timer_en_reg <= !erase_timer_off;
		end
	end

	// =================================================================
	// Event detection
	// Lock history for the falling edge of video lock.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lock_prev_reg <= 1'h0;
		end else begin
			lock_prev_reg <= video_locked;
		end
	end

	// Lock loss and mode change events.
	assign lock_lost   = lock_prev_reg && !video_locked;
	assign mode_change = cfg_load && (mode_sel != mode_reg);

	line21_detect #(
		.RUNIN          (`RUNIN_CYCLES)
	) u_detect (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.line21_gate    (line21_gate),
		.runin_cycle    (runin_cycle),
		.start_bit      (start_bit),
		.check_done_reg (check_done),
		.check_pass_reg (check_pass)
	);

	// Only the field that carries the selected channel is judged.
	assign field_hit = check_done &&
		(field_even == mode_in_field2(mode_reg));

	// Latest verdict for the selected field.
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !video_locked) begin
			wave_ok_reg <= 1'h0;
		end else if (field_hit) begin
			wave_ok_reg <= check_pass;
		end
	end

	// =================================================================
	// Interval timers
	// Acquire: waveform must stand without a miss for the full time.
	assign acq_run     = (state_reg == ACQUIRE) && wave_ok_reg;
	assign acq_restart = field_hit && !check_pass;

	// Loss: a valid waveform in the watched field or channel data starts the count over.
	assign loss_run     = (state_reg == SHOWING) && !wave_ok_reg;
	assign loss_restart = chan_data_valid ||
		(field_hit && check_pass);

	// Long erase: caption or XDS modes, enabled, display live.
	assign erase_run = timer_en_reg && mode_has_timer(mode_reg) &&
		(state_reg == SHOWING) && decoder_on_reg;
	assign erase_restart = chan_data_valid || mode_change;

	field_interval #(
		.LIMIT    (ACQ_FIELDS)
	) u_acq (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.tick     (field_tick),
		.run      (acq_run),
		.restart  (acq_restart),
		.done_reg (acq_done)
	);

	field_interval #(
		.LIMIT    (LOSS_FIELDS)
	) u_loss (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.tick     (field_tick),
		.run      (loss_run),
		.restart  (loss_restart),
		.done_reg (loss_done)
	);

	field_interval #(
		.LIMIT    (ERASE_FIELDS)
	) u_erase (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.tick     (field_tick),
		.run      (erase_run),
		.restart  (erase_restart),
		.done_reg (erase_done)
	);

	// =================================================================
	// Autoblank supervisor
	// Next state: acquire until qualified, show until loss or unlock.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ACQUIRE: begin
				if (acq_done && video_locked) begin
					state_next = SHOWING;
				end
			end
			SHOWING: begin
				if (loss_done || lock_lost) begin
					state_next = ACQUIRE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= ACQUIRE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Display is live only when qualified and the user chose it.
	assign show_next = decoder_on_reg && (state_reg == SHOWING) &&
		video_locked;

	// Display and box enables.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			display_on_reg <= 1'h0;
			box_on_reg     <= 1'h0;
		end else begin
			display_on_reg <= show_next;
			box_on_reg     <= show_next && mode_is_text(mode_reg);
		end
	end

	// =================================================================
	// Erase strobes
	// On-screen clear from commands, mode change, lock loss, timers.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clear_shown_reg <= 1'h0;
		end else begin
			clear_shown_reg <=
				(erase_shown_memory_cmd && mode_is_caption(mode_reg)) ||
				mode_change || lock_lost || loss_done ||
				erase_done;
		end
	end

	// Off-screen clear leaves the shown memory alone.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clear_hidden_reg <= 1'h0;
		end else begin
			clear_hidden_reg <= (erase_hidden_memory_cmd &&
				mode_is_caption(mode_reg)) || mode_change;
		end
	end

	// Text clear keeps the background box standing.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			text_clear_reg <= 1'h0;
		end else begin
			text_clear_reg <= start_text_cmd &&
				mode_is_text(mode_reg);
		end
	end

	// =================================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_text_clear;
		start_text_cmd && mode_is_text(mode_reg) && !mode_change &&
			!lock_lost && !loss_done && !erase_done |=>
			text_clear_reg && !clear_shown_reg;
	endproperty
	a_text_clear: assert property (p_text_clear)
		else $error("start text did not clear text alone");

	property p_shown_erase;
		erase_shown_memory_cmd && mode_is_caption(mode_reg) |=>
			clear_shown_reg;
	endproperty
	a_shown_erase: assert property (p_shown_erase)
		else $error("erase shown command lost");

	property p_hidden_only;
		erase_hidden_memory_cmd && mode_is_caption(mode_reg) &&
			!erase_shown_memory_cmd && !mode_change && !lock_lost &&
			!loss_done && !erase_done |=>
			clear_hidden_reg && !clear_shown_reg;
	endproperty
	a_hidden_only: assert property (p_hidden_only)
		else $error("erase hidden touched shown memory");

	property p_mode_change;
		mode_change |=> clear_shown_reg && clear_hidden_reg &&
			mode_reg == $past(mode_sel);
	endproperty
	a_mode_change: assert property (p_mode_change)
		else $error("mode change did not clear display");

	property p_lock_loss;
		lock_prev_reg && !video_locked && !cfg_load |=>
			clear_shown_reg && $stable(mode_reg) &&
			$stable(decoder_on_reg) ##1 !display_on_reg;
	endproperty
	a_lock_loss: assert property (p_lock_loss)
		else $error("lock loss handling wrong");

	property p_hold_off;
		!decoder_on_reg || state_reg == ACQUIRE |=> !display_on_reg;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("display shown before qualification");

	property p_loss_blank;
		loss_done |=> clear_shown_reg && state_reg == ACQUIRE;
	endproperty
	a_loss_blank: assert property (p_loss_blank)
		else $error("loss timeout did not blank");

	property p_data_restart;
		chan_data_valid |=> !loss_done && !erase_done;
	endproperty
	a_data_restart: assert property (p_data_restart)
		else $error("data did not restart timers");

	property p_timer_modes;
		erase_done |-> mode_has_timer($past(mode_reg)) &&
			$past(timer_en_reg);
	endproperty
	a_timer_modes: assert property (p_timer_modes)
		else $error("erase timer fired in wrong mode");

	property p_timer_keep;
		erase_done && !cfg_load |=> clear_shown_reg &&
			$stable(mode_reg) && $stable(decoder_on_reg);
	endproperty
	a_timer_keep: assert property (p_timer_keep)
		else $error("timer erase wrong");

	property p_reset_state;
		disable iff (1'b0)
		!rst_n |=> mode_reg == first_caption_channel &&
			!decoder_on_reg && !display_on_reg;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");

	c_acquire: cover property (acq_done ##1 state_reg == SHOWING);
	c_loss:    cover property (loss_done);
	c_erase:   cover property (erase_done);
	c_unlock:  cover property (lock_lost && decoder_on_reg);

endmodule

//--- verif/line21_source.sv
// Line 21 slicer and field timing model that feeds the erase block.
`timescale 1ns/100ps
module line21_source (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Waveform presence per field and a short run-in fault.
	input  wire logic wave_odd,
	input  wire logic wave_even,
	input  wire logic short_runin,
	// Slicer and field timing events.
	output logic      field_tick,
	output logic      field_even,
	output logic      line21_gate,
	output logic      runin_cycle,
	output logic      start_bit
);
	logic [4:0] phase_reg;
	logic       good;
	logic [4:0] runin_end;

	// Each field lasts 32 cycles; a waveform is sent only if enabled.
	assign good      = field_even ? wave_even : wave_odd;
	assign runin_end = short_runin ? 5'h0E : 5'h10;

	// Phase within the field, and the parity of the field.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_reg  <= 5'h00;
			field_even <= 1'h0;
		end else begin
			phase_reg <= phase_reg + 5'h01;
			if (phase_reg == 5'h1F)
				field_even <= !field_even;
		end
	end

	// Gate, run-in pulses on even phases, start bit, then the tick.
	always_ff @(posedge sys_clk) begin
		line21_gate <= rst_n && (phase_reg >= 5'h01) && (phase_reg < 5'h12);
		runin_cycle <= rst_n && good && (phase_reg >= 5'h02) &&
			(phase_reg < runin_end) && !phase_reg[0];
		start_bit   <= rst_n && good && (phase_reg == 5'h10);
		field_tick  <= rst_n && (phase_reg == 5'h18);
	end
endmodule

//--- verif/tb.sv
// Self-checking bench for the caption erase and autoblank block.
`timescale 1ns/100ps
module tb
	import caption_erase_pkg::*;
;
	// =================================================================
	// Signals
	localparam int ACQ_F   = 3;
	localparam int LOSS_F  = 4;
	localparam int ERASE_F = 6;

	typedef struct {
		display_mode_e mode;
		logic [2:0]    cmd;
		logic [2:0]    exp;
	} cmd_row_s;

	logic          sys_clk, rst_n, field_tick, field_even, video_locked;
	logic          line21_gate, runin_cycle, start_bit, chan_data_valid;
	logic          start_text_cmd, erase_shown_memory_cmd;
	logic          erase_hidden_memory_cmd, cfg_load, decoder_on_sel;
	logic          erase_timer_off, wave_odd, wave_even, short_runin;
	logic          decoder_on_reg, timer_en_reg, display_on_reg, box_on_reg;
	logic          clear_shown_reg, clear_hidden_reg, text_clear_reg;
	display_mode_e mode_sel, mode_reg;
	int            bad_count, compares, fc, fo;

	// Command bits: start text, erase shown, erase hidden; same for clears.
	cmd_row_s rows [8] = '{
		'{first_caption_channel, 3'h2, 3'h2},
		'{first_caption_channel, 3'h1, 3'h1},
		'{first_caption_channel, 3'h4, 3'h0},
		'{text_one, 3'h4, 3'h4},
		'{text_one, 3'h2, 3'h0},
		'{text_four, 3'h4, 3'h4},
		'{fourth_caption_channel, 3'h1, 3'h1},
		'{full_info_template, 3'h2, 3'h0}};

	// =================================================================
	// Instances
	line21_source u_src (.sys_clk(sys_clk), .rst_n(rst_n),
		.wave_odd(wave_odd), .wave_even(wave_even),
		.short_runin(short_runin), .field_tick(field_tick),
		.field_even(field_even), .line21_gate(line21_gate),
		.runin_cycle(runin_cycle), .start_bit(start_bit));

	caption_display_erase_autoblank #(.ACQ_FIELDS(ACQ_F),
		.LOSS_FIELDS(LOSS_F), .ERASE_FIELDS(ERASE_F)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .field_tick(field_tick),
		.field_even(field_even), .video_locked(video_locked),
		.line21_gate(line21_gate), .runin_cycle(runin_cycle),
		.start_bit(start_bit), .chan_data_valid(chan_data_valid),
		.start_text_cmd(start_text_cmd),
		.erase_shown_memory_cmd(erase_shown_memory_cmd),
		.erase_hidden_memory_cmd(erase_hidden_memory_cmd),
		.cfg_load(cfg_load), .mode_sel(mode_sel),
		.decoder_on_sel(decoder_on_sel), .erase_timer_off(erase_timer_off),
		.mode_reg(mode_reg), .decoder_on_reg(decoder_on_reg),
		.timer_en_reg(timer_en_reg), .display_on_reg(display_on_reg),
		.box_on_reg(box_on_reg), .clear_shown_reg(clear_shown_reg),
		.clear_hidden_reg(clear_hidden_reg),
		.text_clear_reg(text_clear_reg));

	// =================================================================
	// Tasks
	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Compares one output bit.
	task automatic check_bit(input logic got, input logic exp, string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %b want %b", $time, what, got, exp);
		end
	endtask

	// Compares the selected mode.
	task automatic check_mode(input display_mode_e got,
		input display_mode_e exp, input string what);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
		end
	endtask

	// Compares a field count against its allowed range.
	task automatic check_range(input int got, lo, hi, input string what);
		compares++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("BAD %0t %s got %0d want %0d..%0d", $time, what, got,
				lo, hi);
		end
	endtask

	// Loads a mode and decoder state; returns with the answer settled.
	task automatic set_mode(input display_mode_e m, input logic on);
		@(posedge sys_clk);
		cfg_load       <= 1'h1;
		mode_sel       <= m;
		decoder_on_sel <= on;
		@(posedge sys_clk);
		cfg_load <= 1'h0;
		#1;
	endtask

	// Pulses the decoded command bits for one cycle.
	task automatic send_cmd(input logic [2:0] c);
		@(posedge sys_clk);
		{start_text_cmd, erase_shown_memory_cmd, erase_hidden_memory_cmd} <= c;
		@(posedge sys_clk);
		{start_text_cmd, erase_shown_memory_cmd, erase_hidden_memory_cmd} <=
			3'h0;
		#1;
	endtask

	// Runs n fields; notes the field count at the first clear and first
	// shown display, and sends channel data after every k-th tick.
	task automatic run_fields(input int n, k, input logic stop_on,
		output int first_clear, output int first_on);
		int   ticks;
		logic pend;
		ticks       = 0;
		pend        = 1'h0;
		first_clear = -1;
		first_on    = -1;
		for (int cyc = 0; cyc < n * 32; cyc++) begin
			@(posedge sys_clk);
			chan_data_valid <= pend;
			#1;
			pend = 1'h0;
			if (field_tick === 1'h1) begin
				ticks++;
				pend = (k > 0) && (ticks % k == 0);
			end
			if (clear_shown_reg === 1'h1 && first_clear < 0)
				first_clear = ticks;
			if (display_on_reg === 1'h1 && first_on < 0)
				first_on = ticks;
			if (stop_on && first_on >= 0)
				break;
		end
		if (stop_on && first_on < 0) begin
			bad_count++;
			$display("BAD %0t display never came on", $time);
			stop_test();
		end
		@(posedge sys_clk);
		chan_data_valid <= pend;
		@(posedge sys_clk);
		chan_data_valid <= 1'h0;
	endtask

	// =================================================================
	// Clock and main sequence
	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = !sys_clk;
	end

	initial begin
		{rst_n, chan_data_valid, start_text_cmd} = 3'h0;
		{erase_shown_memory_cmd, erase_hidden_memory_cmd, cfg_load} = 3'h0;
		{decoder_on_sel, erase_timer_off, wave_odd, wave_even} = 4'h0;
		short_runin  = 1'h0;
		video_locked = 1'h1;
		mode_sel     = first_caption_channel;
		bad_count    = 0;
		compares     = 0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1;
		check_mode(mode_reg, first_caption_channel, "reset mode");
		check_bit(decoder_on_reg, 1'h0, "reset decoder");
		check_bit(timer_en_reg, 1'h1, "reset timer");
		check_bit(display_on_reg, 1'h0, "reset display");
		// Every mode in turn, each a change from the one before.
		for (int i = 1; i <= 11; i++) begin
			set_mode(display_mode_e'(4'(i % 11)), 1'h0);
			check_mode(mode_reg, display_mode_e'(4'(i % 11)), "load");
			check_bit(clear_shown_reg & clear_hidden_reg, 1'h1, "chg");
		end
		set_mode(first_caption_channel, 1'h1);
		check_bit(clear_shown_reg | clear_hidden_reg, 1'h0, "same");
		check_bit(decoder_on_reg, 1'h1, "decoder on");
		// Command rows, including commands refused in the wrong mode.
		foreach (rows[r]) begin
			set_mode(rows[r].mode, 1'h1);
			send_cmd(rows[r].cmd);
			check_bit(text_clear_reg, rows[r].exp[2], "text");
			check_bit(clear_shown_reg, rows[r].exp[1], "shown");
			check_bit(clear_hidden_reg, rows[r].exp[0], "hidden");
		end
		// Waveform only in the other field, then in the watched one.
		set_mode(first_caption_channel, 1'h1);
		@(posedge sys_clk);
		wave_even <= 1'h1;
		run_fields(8, 0, 1'h0, fc, fo);
		check_range(fo, -1, -1, "wrong field");
		@(posedge sys_clk);
		wave_odd <= 1'h1;
		run_fields(12, 0, 1'h1, fc, fo);
		check_range(fo, ACQ_F, ACQ_F + 2, "acquire");
		run_fields(8, 0, 1'h0, fc, fo);
		check_range(fc, ERASE_F, ERASE_F, "erase timer");
		check_bit(display_on_reg, 1'h1, "kept on");
		check_mode(mode_reg, first_caption_channel, "kept mode");
		// Text mode: no timer erase; start text keeps the box.
		set_mode(text_one, 1'h1);
		run_fields(10, 0, 1'h0, fc, fo);
		check_range(fc, -1, -1, "timer in text");
		send_cmd(3'h4);
		check_bit(text_clear_reg & box_on_reg, 1'h1, "box kept");
		// Timer switched off in caption mode.
		set_mode(first_caption_channel, 1'h1);
		@(posedge sys_clk);
		erase_timer_off <= 1'h1;
		run_fields(10, 0, 1'h0, fc, fo);
		check_range(fc, -1, -1, "timer off");
		check_bit(timer_en_reg, 1'h0, "timer en");
		@(posedge sys_clk);
		erase_timer_off <= 1'h0;
		// Lock loss clears but keeps mode and decoder state.
		@(posedge sys_clk);
		video_locked <= 1'h0;
		@(posedge sys_clk);
		#1;
		check_bit(clear_shown_reg, 1'h1, "lock clear");
		check_bit(display_on_reg, 1'h0, "lock off");
		check_mode(mode_reg, first_caption_channel, "lock mode");
		check_bit(decoder_on_reg, 1'h1, "lock decoder");
		// Six run-in cycles are not a waveform; seven are.
		@(posedge sys_clk);
		short_runin  <= 1'h1;
		video_locked <= 1'h1;
		run_fields(10, 0, 1'h0, fc, fo);
		check_range(fo, -1, -1, "short run-in");
		@(posedge sys_clk);
		short_runin <= 1'h0;
		run_fields(12, 0, 1'h1, fc, fo);
		check_range(fo, ACQ_F, ACQ_F + 2, "resume");
		// Waveform gone: data holds off blanking, then blanking follows.
		@(posedge sys_clk);
		wave_odd <= 1'h0;
		run_fields(12, 1, 1'h0, fc, fo);
		check_range(fc, -1, -1, "data holds");
		run_fields(8, 0, 1'h0, fc, fo);
		check_range(fc, LOSS_F, LOSS_F + 1, "loss blank");
		check_bit(display_on_reg, 1'h0, "blanked");
		// Reset in mid-run returns to the first channel with decoder off.
		set_mode(text_two, 1'h1);
		@(posedge sys_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1;
		check_mode(mode_reg, first_caption_channel, "rerun mode");
		check_bit(decoder_on_reg | display_on_reg, 1'h0, "off");
		check_bit(timer_en_reg, 1'h1, "rerun timer");
		stop_test();
	end
endmodule
